//--- sra_aligner.sv
// slice rate aligner: six 16-bit cable slices to four 24-bit board slices
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE1: cable slices captured on each edge of the regenerated strobe clock; the code captures on rising edges only
// RULE2: captured slice registered a second time before steering
// RULE3: three slot selects from frame-first, each high in two of six slots
// RULE4: frame-first slice is slot 0 into holding 0, next two into 1 and 2
// RULE5: slot 3 moves holding registers into staging A, slices 4-6 follow
// RULE6: next slot 0 moves slices four to six into staging A
// RULE7: staging A copied into B on the 33ns clock before overwrite
// RULE8: B load phase must stay within about 60ns of A hold window
// RULE9: B split into two 24-bit halves chosen by mux select
// RULE10: even window high in output slots 0 and 2, slot 0 from clocks
// RULE11: mux select is a registered copy of the even window
// RULE12: data, markers, error and run registered on 33ns clock to pins
// RULE13: run flag set on first bunch-zero marker and kept
// RULE14: outgoing frame-first high in both prompt slots, low in delay slots
// RULE15: error when bunch-zero not on all of six consecutive slots
// RULE16: error when frame-first appears more than once in six slots
// RULE17: error flag travels aligned with its data slices
// RULE18: separate bunch-zero and frame-first error pins for board register
// RULE19: output order prompt 0-23, 24-47, delay 0-23, 24-47 with markers
// RULE20: no response to the board global reset pulse
// RULE21: source sends prompt then delay slices, frame-first on first only
// RULE22: source marks all six slices of a bunch-zero period
// RULE23: mux select high passes low half of B, low passes high half
// RULE24: run flag cleared only by local reset or reconfiguration; the code also clears it on an apb write of control bit 0
module sra_aligner (
  input wire logic pclk, // 50 MHz system clock
  input wire logic presetn, // local async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic lnk_clk, // regenerated strobe clock pin
  input wire logic [15:0] cab_data, // cable slice pins
  input wire logic cab_word0, // frame-first marker pin
  input wire logic cab_beam0, // bunch-zero marker pin
  input wire logic clk33, // board 33ns clock pin
  input wire logic clk66, // board 66ns clock pin
  input wire logic clk132, // board 132ns clock, board_main_clock
  output sra_pkg::sra_out_s out_slice, // aligned slice and markers
  output logic out_run, // run flag to finder
  output logic beam0_err, // bunch-zero error pin
  output logic word0_err // frame-first error pin
);

  function automatic logic [2:0] ones6(input logic [5:0] v);
    ones6 = 3'h0;
    for (int i = 0; i < 6; i++) begin
      ones6 = ones6 + {2'h0, v[i]};
    end
  endfunction

  function automatic logic [2:0] slot_next(input logic [2:0] s);
    slot_next = (s == sra_pkg::IN_SLOT_LAST) ? 3'h0 : s + 3'h1;
  endfunction

  // pin synchronisers: four clock pins, two markers, sixteen data bits
  // all pins pass two flops; clock pins are sampled, not used as clocks
  logic [21:0] pin_m;
  logic [21:0] pin_s;
  logic [3:0] edge_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m <= 22'h0;
      pin_s <= 22'h0;
    end else begin
      pin_m <= {clk132, clk66, clk33, lnk_clk, cab_beam0, cab_word0,
                cab_data};
      pin_s <= pin_m;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_d <= 4'h0;
    end else begin
      edge_d <= pin_s[21:18];
    end
  end

  wire sra_pkg::sra_slice_s pin_slice = pin_s[17:0];
  // data and markers move with the strobe through the same two flops
  wire lnk_rise = pin_s[18] & ~edge_d[0];
  wire c33_rise = pin_s[19] & ~edge_d[1];
  wire c66_s = pin_s[20];
  wire c132_s = pin_s[21];

  // input domain: capture and second register
  sra_pkg::sra_slice_s cap;
  sra_pkg::sra_slice_s cap2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= '0;
      cap2 <= '0;
    end else if (lnk_rise) begin
      cap <= pin_slice; // [RULE1]
      cap2 <= cap; // [RULE2]
    end
  end

  // slot tracking and time selects
  logic [2:0] slot;
  wire [2:0] cur_slot = cap2.word0 ? 3'h0 : slot_next(slot); // [RULE3]
  wire [2:0] tsel;
  assign tsel[0] = (cur_slot == 3'h0) || (cur_slot == 3'h3); // [RULE3]
  assign tsel[1] = (cur_slot == 3'h1) || (cur_slot == 3'h4); // [RULE3]
  assign tsel[2] = (cur_slot == 3'h2) || (cur_slot == 3'h5); // [RULE3]
  wire a_load = tsel[0];

  logic [15:0] hold [3];
  logic [2:0] hold_b;
  logic [5:0] whist;
  logic [5:0] bhist;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot <= sra_pkg::RST_SLOT;
      hold_b <= 3'h0;
      whist <= 6'h0;
      bhist <= 6'h0;
      for (int i = 0; i < 3; i++) begin
        hold[i] <= 16'h0;
      end
    end else if (lnk_rise) begin
      slot <= cur_slot;
      whist <= {whist[4:0], cap2.word0};
      bhist <= {bhist[4:0], cap2.beam0};
      for (int i = 0; i < 3; i++) begin
        if (tsel[i]) begin
          hold[i] <= cap2.data; // [RULE4] [RULE5]
          hold_b[i] <= cap2.beam0;
        end
      end
    end
  end

  // marker checks over the last six input slots
  wire word_bad = ones6(whist) > 3'h1; // [RULE16]
  wire beam_bad = (|bhist) & ~(&bhist); // [RULE15]

  // staging A, loaded in slots 3 and 0
  sra_pkg::sra_stage_s stg_a;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_a <= '0;
    end else if (lnk_rise && a_load) begin
      stg_a.data <= {hold[2], hold[1], hold[0]}; // [RULE5] [RULE6]
      stg_a.prompt <= (cur_slot == sra_pkg::IN_SLOT_MID);
      stg_a.beam0 <= |hold_b;
      stg_a.err <= word_bad | beam_bad; // [RULE17]
    end
  end

  // output side: slot from the phase of the board clocks
  logic [1:0] oslot;
  wire [1:0] cur_oslot = (c66_s & c132_s) ? 2'h0 : oslot + 2'h1; // [RULE10]
  logic even_win;
  logic mux_sel;
  sra_pkg::sra_stage_s stg_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oslot <= sra_pkg::RST_OSLOT;
      even_win <= 1'b0;
      mux_sel <= 1'b0;
    end else if (c33_rise) begin
      oslot <= cur_oslot;
      even_win <= ~cur_oslot[0]; // [RULE10]
      mux_sel <= even_win; // [RULE11]
    end
  end

  // B loads one 33ns edge after the even window opens, within A's hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_b <= '0;
    end else if (c33_rise && even_win) begin
      stg_b <= stg_a; // [RULE7] [RULE8]
    end
  end

  wire [23:0] half_sel = mux_sel ? stg_b.data[23:0]
                                 : stg_b.data[47:24]; // [RULE9] [RULE23]

  // run flag, sticky until local reset or software clear
  logic run;
  wire run_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
    end else if (lnk_rise && cap2.beam0) begin
      run <= 1'b1; // [RULE13]
    end else if (run_clr) begin
      run <= 1'b0; // [RULE24]
    end
  end

  // output register on the 33ns edge, presetn is the only reset [RULE20]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_slice <= '0;
      out_run <= 1'b0;
      beam0_err <= 1'b0;
      word0_err <= 1'b0;
    end else if (c33_rise) begin
      out_slice.data <= half_sel; // [RULE12] [RULE19]
      out_slice.word0 <= stg_b.prompt; // [RULE14]
      out_slice.beam0 <= stg_b.beam0;
      out_slice.err <= stg_b.err; // [RULE17]
      out_run <= run; // [RULE12]
      beam0_err <= beam_bad; // [RULE18]
      word0_err <= word_bad; // [RULE18]
    end
  end

  // apb slave, zero wait states
  wire setup = psel & ~penable;
  wire hit_ctrl = paddr == sra_pkg::ADDR_CTRL;
  wire hit_stat = paddr == sra_pkg::ADDR_STATUS;
  wire [31:0] stat_word = {29'h0, word0_err, beam0_err, run};
  assign run_clr = psel & penable & pwrite & hit_ctrl &
                   pwdata[sra_pkg::CTRL_RUN_CLR_BIT]; // [RULE24]
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= (hit_stat && !pwrite) ? stat_word : 32'h0;
    end
  end

  // checks on the input side, one strobe edge at a time
  a_cap_edge: assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise |=> cap == $past(pin_slice))
    else $error("cable slice not captured on strobe edge");

  a_cap_twice: assert property ( // [RULE2]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise |=> cap2 == $past(cap))
    else $error("second cable register did not follow capture");

  a_sel_count: assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
    $onehot(tsel))
    else $error("slot selects not one-hot");

  a_sel_zero: assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && cap2.word0 |-> tsel[0] && cur_slot == 3'h0)
    else $error("select 0 not aligned to frame-first");

  a_slot_step: assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && !cap2.word0 |=> slot == slot_next($past(slot)))
    else $error("input slot did not advance");

  a_hold_zero: assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && cap2.word0 |=> hold[0] == $past(cap2.data))
    else $error("frame-first slice not in holding 0");

  a_hold_next: assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && tsel[1] |=> hold[1] == $past(cap2.data))
    else $error("slice not in holding 1");

  a_stage_load: assert property ( // [RULE5]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && cur_slot == 3'h3 |=> stg_a.prompt &&
      stg_a.data == {$past(hold[2]), $past(hold[1]), $past(hold[0])})
    else $error("staging A not loaded in slot 3");

  a_stage_late: assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && cur_slot == 3'h0 |=> !stg_a.prompt &&
      stg_a.data == {$past(hold[2]), $past(hold[1]), $past(hold[0])})
    else $error("staging A not loaded in slot 0");

  // checks on the output side, one 33ns edge at a time
  a_b_copy: assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && even_win |=> stg_b == $past(stg_a))
    else $error("staging B did not copy A");

  a_b_hold: assert property ( // [RULE8]
    @(posedge pclk) disable iff (!presetn)
    !(c33_rise && even_win) |=> $stable(stg_b))
    else $error("staging B loaded outside its window");

  a_even_win: assert property ( // [RULE10]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && c66_s && c132_s |=> even_win ##1 !c33_rise [*1])
    else $error("even window not opened in slot 0");

  a_even_alt: assert property ( // [RULE10]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> even_win == !$past(cur_oslot[0]))
    else $error("even window not high in even slots");

  a_mux_copy: assert property ( // [RULE11]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> mux_sel == $past(even_win))
    else $error("mux select not a copy of even window");

  a_low_half: assert property ( // [RULE23]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && mux_sel |=> out_slice.data == $past(stg_b.data[23:0]))
    else $error("mux select high did not pass low half");

  a_high_half: assert property ( // [RULE9]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && !mux_sel |=> out_slice.data == $past(stg_b.data[47:24]))
    else $error("mux select low did not pass high half");

  a_out_run: assert property ( // [RULE12]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> out_run == $past(run))
    else $error("run pin not registered copy of run flag");

  a_out_hold: assert property ( // [RULE12]
    @(posedge pclk) disable iff (!presetn)
    !c33_rise |=> $stable(out_slice) && $stable(out_run))
    else $error("output pins moved between 33ns edges");

  a_word0_out: assert property ( // [RULE14]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> out_slice.word0 == $past(stg_b.prompt))
    else $error("outgoing frame-first not from prompt image");

  a_err_travel: assert property ( // [RULE17]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> out_slice.err == $past(stg_b.err))
    else $error("error flag not carried with its slice");

  // run flag and marker errors
  a_run_set: assert property ( // [RULE13]
    @(posedge pclk) disable iff (!presetn)
    lnk_rise && cap2.beam0 |=> run)
    else $error("run flag not set on bunch-zero");

  a_run_sticky: assert property ( // [RULE13]
    @(posedge pclk) disable iff (!presetn)
    run && !run_clr |=> run)
    else $error("run flag dropped without clear");

  a_run_clear: assert property ( // [RULE24]
    @(posedge pclk) disable iff (!presetn)
    run_clr && !(lnk_rise && cap2.beam0) |=> !run)
    else $error("run flag not cleared by software");

  a_word_err: assert property ( // [RULE16]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && ones6(whist) > 3'h1 |=> word0_err)
    else $error("double frame-first not flagged");

  a_beam_err: assert property ( // [RULE15]
    @(posedge pclk) disable iff (!presetn)
    c33_rise && (|bhist) && !(&bhist) |=> beam0_err)
    else $error("partial bunch-zero not flagged");

  a_err_pins: assert property ( // [RULE18]
    @(posedge pclk) disable iff (!presetn)
    c33_rise |=> beam0_err == $past(beam_bad) &&
      word0_err == $past(word_bad))
    else $error("error pins not registered from marker checks");
endmodule
`default_nettype wire

//--- sra_pkg.sv
// constants and carrier types for the slice rate aligner
package sra_pkg;
  // slot geometry
  localparam int IN_SLOTS = 6;
  localparam logic [2:0] IN_SLOT_LAST = 3'h5;
  localparam logic [2:0] IN_SLOT_MID = 3'h3;
  localparam int OUT_SLOTS = 4;
  localparam int SLICE_W = 16;
  localparam int STAGE_W = 48;
  localparam int OUT_W = 24;
  // nominal times in ns
  localparam int T_IN_SLOT_NS = 22;
  localparam int T_OUT_SLOT_NS = 33;
  localparam int T_PERIOD_NS = 132;
  localparam int T_HOLD_A_NS = 66;
  localparam int T_B_SHIFT_NS = 60;
  localparam int CLK_PERIOD_NS = 20;
  // hold of staging A in pclk cycles, rounded down
  localparam int HOLD_A_CYC = T_HOLD_A_NS / CLK_PERIOD_NS;
  // apb map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_RUN_CLR_BIT = 0;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_BEAM_ERR_BIT = 1;
  localparam int ST_WORD_ERR_BIT = 2;
  localparam logic [2:0] RST_SLOT = 3'h5;
  localparam logic [1:0] RST_OSLOT = 2'h3;

  typedef struct packed {
    logic beam0;
    logic word0;
    logic [SLICE_W-1:0] data;
  } sra_slice_s;

  typedef struct packed {
    logic err;
    logic word0;
    logic beam0;
    logic [OUT_W-1:0] data;
  } sra_out_s;

  typedef struct packed {
    logic err;
    logic prompt;
    logic beam0;
    logic [STAGE_W-1:0] data;
  } sra_stage_s;
endpackage

//--- sra_cable_src.sv
// cable source and board clock model driving the aligner inputs
`timescale 1ns/100ps
`default_nettype none
module sra_cable_src (
  input wire logic [95:0] frame, // six slices, slice 0 lowest
  input wire logic [5:0] beam_mask, // bunch-zero per slice
  input wire logic [5:0] word_mask, // frame-first per slice
  output logic lnk_clk, // strobe clock, one slice per period
  output logic [15:0] cab_data, // slice pins
  output logic cab_word0, // frame-first pin
  output logic cab_beam0, // bunch-zero pin
  output logic clk33, // board slot clock
  output logic clk66, // board half-period clock
  output logic clk132 // board period clock
);
  int slot;
  logic [2:0] bcnt;
  // strobe runs free, one rising edge per slice
  initial begin
    lnk_clk = 1'b0;
    forever #80 lnk_clk = ~lnk_clk;
  end
  // slices change on the falling edge, stable at the rise
  initial begin
    slot = 5;
    cab_data = 16'h0000;
    cab_word0 = 1'b0;
    cab_beam0 = 1'b0;
    forever begin
      @(negedge lnk_clk);
      slot = (slot + 1) % 6;
      cab_data = frame[slot*16 +: 16];
      cab_word0 = word_mask[slot];
      cab_beam0 = beam_mask[slot];
    end
  end
  // all three high at the rise that opens output slot 0
  initial begin
    bcnt = 3'h0;
    forever begin
      clk33 = ~bcnt[0];
      clk66 = ~bcnt[1];
      clk132 = ~bcnt[2];
      #120 bcnt = bcnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- test_slice_rate_aligner.sv
// self-checking bench for the slice rate aligner
`timescale 1ns/100ps
`default_nettype none
module test_slice_rate_aligner;
  localparam logic [95:0] FRAME = 96'hc6c5_b4b3_a2a1_9f9e_8d8c_7b7a;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic lnk_clk, cab_word0, cab_beam0, clk33, clk66, clk132;
  logic out_run, beam0_err, word0_err;
  logic [15:0] cab_data;
  logic [5:0] beam_mask, word_mask;
  sra_pkg::sra_out_s out_slice;
  int error_cnt, n_compared;
  sra_aligner dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk_clk(lnk_clk), .cab_data(cab_data), .cab_word0(cab_word0),
    .cab_beam0(cab_beam0), .clk33(clk33), .clk66(clk66), .clk132(clk132),
    .out_slice(out_slice), .out_run(out_run), .beam0_err(beam0_err),
    .word0_err(word0_err));
  sra_cable_src src_u (.frame(FRAME), .beam_mask(beam_mask),
    .word_mask(word_mask), .lnk_clk(lnk_clk), .cab_data(cab_data),
    .cab_word0(cab_word0), .cab_beam0(cab_beam0), .clk33(clk33),
    .clk66(clk66), .clk132(clk132));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
    chk(pready === 1'b1, "no ready on bus");
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_src(input logic [5:0] b, input logic [5:0] w);
    @(posedge pclk);
    beam_mask <= b;
    word_mask <= w;
  endtask
  // output slot s: even slots low half, prompt in slots 0 and 1
  function automatic sra_pkg::sra_out_s exp(input int s, input logic b0,
                                            input logic er);
    return {er, s < 2, b0, FRAME[48*(s/2) + 24*(s%2) +: 24]};
  endfunction
  task automatic see_out(input sra_pkg::sra_out_s e, input string msg);
    for (int k = 0; k < 400 && out_slice !== e; k++) @(negedge pclk);
    chk(out_slice === e, msg);
  endtask
  function automatic logic flag(input int s);
    return s == 0 ? out_run : s == 1 ? beam0_err :
           s == 2 ? word0_err : out_slice.err;
  endfunction
  task automatic see_flag(input int s, input logic v, input string msg);
    for (int k = 0; k < 400 && flag(s) !== v; k++) @(negedge pclk);
    chk(flag(s) === v, msg);
  endtask
  task automatic t_bus;
    apb(1'b0, sra_pkg::ADDR_STATUS, 32'h0);
    chk(rd === 32'h0 && rerr === 1'b0, "status after reset");
    apb(1'b0, 8'h08, 32'h0);
    chk(rerr === 1'b1 && rd === 32'h0, "unmapped read");
    $display("bus test done");
  endtask
  task automatic t_no_beam;
    for (int s = 0; s < 4; s++) see_out(exp(s, 1'b0, 1'b0), "slice");
    chk(out_run === 1'b0, "run without bunch zero");
    $display("no beam test done");
  endtask
  task automatic t_beam;
    set_src(6'h3f, 6'h01);
    see_flag(0, 1'b1, "run not set");
    for (int s = 0; s < 4; s++) see_out(exp(s, 1'b1, 1'b0), "slice");
    chk(beam0_err === 1'b0 && word0_err === 1'b0, "false error");
    apb(1'b0, sra_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2:0] === 3'b001, "status with run");
    $display("beam test done");
  endtask
  task automatic t_run_clear;
    set_src(6'h00, 6'h01);
    repeat (200) @(negedge pclk);
    chk(out_run === 1'b1, "run dropped");
    apb(1'b1, sra_pkg::ADDR_CTRL, 32'h1);
    see_flag(0, 1'b0, "run not cleared");
    apb(1'b0, sra_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0] === 1'b0, "status run");
    $display("run clear test done");
  endtask
  task automatic t_beam_err;
    set_src(6'h07, 6'h01);
    see_flag(1, 1'b1, "bunch-zero error");
    see_flag(3, 1'b1, "error flag in slice");
    chk(word0_err === 1'b0, "wrong error pin");
    apb(1'b0, sra_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1] === 1'b1, "status bunch-zero error");
    $display("beam error test done");
  endtask
  task automatic t_word_err;
    set_src(6'h3f, 6'h09);
    see_flag(2, 1'b1, "frame-first error");
    see_flag(1, 1'b0, "bunch-zero error stuck");
    apb(1'b0, sra_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2] === 1'b1, "status frame-first error");
    set_src(6'h3f, 6'h01);
    see_flag(2, 1'b0, "frame-first error stuck");
    see_out(exp(0, 1'b1, 1'b0), "slice after recovery");
    $display("word error test done");
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    beam_mask = 6'h00;
    word_mask = 6'h01;
    error_cnt = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    chk(pready === 1'b1 && out_run === 1'b0, "reset outputs");
    chk(out_slice === '0 && {beam0_err, word0_err} === 2'b00, "reset pins");
    presetn <= 1'b1;
    t_bus();
    t_no_beam();
    t_beam();
    t_run_clear();
    t_beam_err();
    t_word_err();
    print_verdict();
  end
endmodule
`default_nettype wire
